/* File: design/igc_global_cmd.sv */
// global command interpreter and identification registers behind the serial port
`timescale 1ns/1ps
module igc_global_cmd
  import igc_pkg::*;
#(
  parameter logic [15:0] FW_REVISION = 16'h0100,
  parameter logic [15:0] CFG_DAY_MONTH = 16'h0101,
  parameter logic [15:0] CFG_YEAR = 16'h2000,
  // arbitrary identification value
  parameter logic [15:0] PRODUCT_ID = 16'h1234,
  parameter logic [15:0] LOT_SERIAL = 16'h0001,
  parameter logic [15:0] ST_DELTA_MIN = 16'h0010,
  parameter logic [15:0] ST_DELTA_MAX = 16'h4000
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // serial link, host is master
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // flash engine
  output logic flash_crc_req,
  input wire logic flash_crc_done,
  input wire logic [15:0] flash_crc_value,
  input wire logic [15:0] factory_crc,
  output logic flash_save_req,
  input wire logic flash_save_done,
  input wire logic flash_save_fail,
  output logic [15:0] scratch_one_out,
  output logic [15:0] scratch_two_out,
  output logic [15:0] scratch_three_out,
  // sensor self test
  output logic sensor_meas_req,
  input wire logic sensor_meas_done,
  input wire logic [95:0] sensor_meas_data,
  output logic stimulus_enable,
  // restore and bias
  output logic settings_restore,
  output logic offset_clear_wr,
  output logic [3:0] offset_clear_index,
  output logic [15:0] offset_clear_data,
  output logic bias_apply,
  // data path gating
  input wire logic sample_ready_in,
  output logic sample_ready_line,
  output logic halt_data_production,
  // diagnostic flags
  output logic [15:0] diag_flags
);

  // ---------------- link domain ----------------
  logic link_clr;
  logic [3:0] rise_cnt;
  logic [3:0] next_rise_cnt;
  logic [14:0] rx_shift;
  logic [14:0] next_rx_shift;
  logic [15:0] rx_word;
  logic [15:0] next_rx_word;
  logic rx_tog;
  logic next_rx_tog;
  logic [3:0] fall_cnt;
  logic [3:0] next_fall_cnt;
  logic [15:0] rd_word;

  // frame counters restart whenever the select is released
  assign link_clr = cs_n | ~rst_n;

  always_comb begin
    next_rise_cnt = rise_cnt + 4'h1;
    next_rx_shift = {rx_shift[13:0], din};
    next_rx_word = rx_word;
    next_rx_tog = rx_tog;
    if (rise_cnt == 4'hf) begin
      next_rx_word = {rx_shift, din};
      next_rx_tog = ~rx_tog;
    end
  end

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      rise_cnt <= 4'h0;
      rx_shift <= 15'h0000;
    end else begin
      rise_cnt <= next_rise_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // word and toggle survive the end of frame for the system side
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word <= 16'h0000;
      rx_tog <= 1'b0;
    end else begin
      rx_word <= next_rx_word;
      rx_tog <= next_rx_tog;
    end
  end

  always_comb begin
    next_fall_cnt = fall_cnt + 4'h1;
  end

  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      fall_cnt <= 4'h0;
    end else begin
      fall_cnt <= next_fall_cnt;
    end
  end

  // rd_word only changes in the stall between frames, so it is quiet here
  // idle-high clock: the first falling edge presents the msb, the wrap at 16 lands on bit 0
  assign dout = rd_word[4'h0 - fall_cnt];
  assign dout_oe = ~cs_n;

  // ---------------- system domain ----------------
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic word_new;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
    end else if (clk_en) begin
      tog_meta <= rx_tog;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
    end
  end

  assign word_new = tog_sync ^ tog_seen;

  igc_state_t state;
  igc_state_t next_state;
  logic [4:0] cmd_pend;
  logic [4:0] next_cmd_pend;
  logic [7:0] cmd_byte;
  logic [7:0] next_cmd_byte;
  logic [15:0] scratch [3];
  logic [15:0] next_scratch [3];
  logic [31:0] fwr_count;
  logic [31:0] next_fwr_count;
  logic [15:0] next_rd_word;
  logic [15:0] meas_off [SENSOR_N];
  logic [15:0] next_meas_off [SENSOR_N];
  logic st_fail;
  logic next_st_fail;
  logic [3:0] clr_idx;
  logic [3:0] next_clr_idx;
  logic fl_test_fail;
  logic next_fl_test_fail;
  logic fl_save_fail;
  logic next_fl_save_fail;
  logic st_flag;
  logic next_st_flag;
  logic busy;
  logic wr_req;
  logic rd_req;
  logic [6:0] req_addr;
  logic [7:0] req_data;
  logic st_judge_fail;

  // lowest numbered pending command runs first
  function automatic igc_state_t igc_pick(input logic [4:0] pend);
    igc_state_t pick;
    pick = IGC_IDLE;
    if (pend[CMD_BIAS_UPDATE]) pick = IGC_BIAS;
    else if (pend[CMD_RESTORE]) pick = IGC_RESTORE;
    else if (pend[CMD_SELF_TEST]) pick = IGC_SMEAS0;
    else if (pend[CMD_FLASH_UPDATE]) pick = IGC_FSAVE;
    else if (pend[CMD_FLASH_TEST]) pick = IGC_FTEST;
    return pick;
  endfunction

  assign busy = (state != IGC_IDLE) || (cmd_pend != 5'h00);
  assign wr_req = word_new && !busy && rx_word[15];
  assign rd_req = word_new && !busy && !rx_word[15];
  assign req_addr = rx_word[14:8];
  assign req_data = rx_word[7:0];

  always_comb begin
    logic [15:0] delta;
    delta = 16'h0000;
    st_judge_fail = 1'b0;
    for (int s = 0; s < SENSOR_N; s++) begin
      delta = sensor_meas_data[s*16 +: 16] - meas_off[s];
      if (delta < ST_DELTA_MIN || delta > ST_DELTA_MAX) begin
        st_judge_fail = 1'b1;
      end
    end
  end

  // register writes and read answers
  always_comb begin
    next_cmd_byte = cmd_byte;
    next_scratch = scratch;
    next_rd_word = rd_word;
    if (wr_req) begin
      unique case (req_addr)
        ADDR_CMD_LO: next_cmd_byte = req_data;
        // byte consumed by the start write
        ADDR_CMD_HI: next_cmd_byte = 8'h00;
        // scratch words written a byte at a time
        ADDR_SCR_ONE: next_scratch[0][7:0] = req_data;
        ADDR_SCR_ONE + 7'h01: next_scratch[0][15:8] = req_data;
        ADDR_SCR_TWO: next_scratch[1][7:0] = req_data;
        ADDR_SCR_TWO + 7'h01: next_scratch[1][15:8] = req_data;
        ADDR_SCR_THREE: next_scratch[2][7:0] = req_data;
        ADDR_SCR_THREE + 7'h01: next_scratch[2][15:8] = req_data;
        default: next_cmd_byte = cmd_byte;
      endcase
    end
    if (rd_req) begin
      unique case ({req_addr[6:1], 1'b0})
        ADDR_FW_REV: next_rd_word = FW_REVISION;
        ADDR_CFG_DM: next_rd_word = CFG_DAY_MONTH;
        ADDR_CFG_YEAR: next_rd_word = CFG_YEAR;
        ADDR_PRODUCT_IDENTIFIER: next_rd_word = PRODUCT_ID;
        ADDR_SERIAL: next_rd_word = LOT_SERIAL;
        ADDR_SCR_ONE: next_rd_word = scratch[0];
        ADDR_SCR_TWO: next_rd_word = scratch[1];
        ADDR_SCR_THREE: next_rd_word = scratch[2];
        ADDR_FWR_LO: next_rd_word = fwr_count[15:0];
        ADDR_FWR_HI: next_rd_word = fwr_count[31:16];
        default: next_rd_word = 16'h0000;
      endcase
    end
  end

  // command sequencer
  always_comb begin
    next_state = state;
    next_cmd_pend = cmd_pend;
    next_fwr_count = fwr_count;
    next_meas_off = meas_off;
    next_st_fail = st_fail;
    next_clr_idx = clr_idx;
    next_fl_test_fail = fl_test_fail;
    next_fl_save_fail = fl_save_fail;
    next_st_flag = st_flag;
    unique case (state)
      IGC_IDLE: begin
        // second word to the high byte starts the byte held
        if (wr_req && req_addr == ADDR_CMD_HI) begin
          // ones in the low five bits of the byte trigger commands
          next_cmd_pend = cmd_byte[CMD_N-1:0];
        end else if (cmd_pend != 5'h00) begin
          next_state = igc_pick(cmd_pend);
          next_clr_idx = 4'h0;
        end
      end
      // CRC run by flash engine, compared here
      IGC_FTEST: begin
        if (flash_crc_done) begin
          next_fl_test_fail = (flash_crc_value != factory_crc);
          next_cmd_pend[CMD_FLASH_TEST] = 1'b0;
          next_state = IGC_IDLE;
        end
      end
      IGC_FSAVE: begin
        if (flash_save_done) begin
          next_fl_save_fail = flash_save_fail;
          next_fwr_count = fwr_count + 32'h0000_0001;
          next_cmd_pend[CMD_FLASH_UPDATE] = 1'b0;
          next_state = IGC_IDLE;
        end
      end
      IGC_SMEAS0: begin
        if (sensor_meas_done) begin
          for (int s = 0; s < SENSOR_N; s++) begin
            next_meas_off[s] = sensor_meas_data[s*16 +: 16];
          end
          next_state = IGC_SSTIM;
        end
      end
      IGC_SSTIM: next_state = IGC_SMEAS1;
      IGC_SMEAS1: begin
        if (sensor_meas_done) begin
          next_st_fail = st_judge_fail;
          next_state = IGC_SUNSTIM;
        end
      end
      IGC_SUNSTIM: next_state = IGC_SJUDGE;
      IGC_SJUDGE: begin
        // result posted once stimulus is off
        next_st_flag = st_fail;
        next_cmd_pend[CMD_SELF_TEST] = 1'b0;
        next_state = IGC_IDLE;
      end
      IGC_RESTORE: begin
        next_clr_idx = clr_idx + 4'h1;
        if (clr_idx == 4'(OFFSET_REG_N - 1)) begin
          next_cmd_pend[CMD_RESTORE] = 1'b0;
          next_state = IGC_IDLE;
        end
      end
      IGC_BIAS: begin
        next_cmd_pend[CMD_BIAS_UPDATE] = 1'b0;
        next_state = IGC_IDLE;
      end
      default: next_state = IGC_IDLE;
    endcase
  end

  // trigger bits vanish as each command ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IGC_IDLE;
      cmd_pend <= 5'h00;
      cmd_byte <= 8'h00;
      fwr_count <= FWR_COUNT_RST;
      st_fail <= 1'b0;
      clr_idx <= 4'h0;
      fl_test_fail <= 1'b0;
      fl_save_fail <= 1'b0;
      st_flag <= 1'b0;
      rd_word <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        scratch[i] <= SCRATCH_RST;
      end
      for (int s = 0; s < SENSOR_N; s++) begin
        meas_off[s] <= 16'h0000;
      end
    end else if (clk_en) begin
      state <= next_state;
      cmd_pend <= next_cmd_pend;
      cmd_byte <= next_cmd_byte;
      fwr_count <= next_fwr_count;
      st_fail <= next_st_fail;
      clr_idx <= next_clr_idx;
      fl_test_fail <= next_fl_test_fail;
      fl_save_fail <= next_fl_save_fail;
      st_flag <= next_st_flag;
      rd_word <= next_rd_word;
      scratch <= next_scratch;
      meas_off <= next_meas_off;
    end
  end

  // ---------------- outputs ----------------
  logic next_stim;
  logic stim;
  logic next_sample_ready;
  logic sample_ready;
  logic next_restore_pulse;
  logic restore_pulse;

  always_comb begin
    next_stim = stim;
    if (state == IGC_SSTIM) next_stim = 1'b1;
    if (state == IGC_SUNSTIM) next_stim = 1'b0;
    // ready pulses held back during commands
    next_sample_ready = sample_ready_in && !busy;
    // defaults restored as the command starts
    next_restore_pulse = (state == IGC_IDLE) && (next_state == IGC_RESTORE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stim <= 1'b0;
      sample_ready <= 1'b0;
      restore_pulse <= 1'b0;
    end else if (clk_en) begin
      stim <= next_stim;
      sample_ready <= next_sample_ready;
      restore_pulse <= next_restore_pulse;
    end
  end

  assign stimulus_enable = stim;
  assign sample_ready_line = sample_ready;
  assign settings_restore = restore_pulse;
  assign halt_data_production = busy;
  assign flash_crc_req = (state == IGC_FTEST);
  assign flash_save_req = (state == IGC_FSAVE);
  assign sensor_meas_req = (state == IGC_SMEAS0) || (state == IGC_SMEAS1);
  assign offset_clear_wr = (state == IGC_RESTORE);
  assign offset_clear_index = clr_idx;
  assign offset_clear_data = OFFSET_CLEAR_VALUE;
  assign bias_apply = (state == IGC_BIAS);
  assign scratch_one_out = scratch[0];
  assign scratch_two_out = scratch[1];
  assign scratch_three_out = scratch[2];

  always_comb begin
    diag_flags = 16'h0000;
    diag_flags[DIAG_FLASH_TEST] = fl_test_fail;
    diag_flags[DIAG_SELF_TEST] = st_flag;
    diag_flags[DIAG_FLASH_UPDATE] = fl_save_fail;
  end

endmodule

/* File: dv/igc_global_cmd_asserts.sv */
// port-level checks for the global command block
`timescale 1ns/1ps
module igc_global_cmd_asserts
  import igc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // engine handshakes
  input wire logic flash_crc_req,
  input wire logic flash_crc_done,
  input wire logic [15:0] flash_crc_value,
  input wire logic [15:0] factory_crc,
  input wire logic flash_save_req,
  input wire logic flash_save_done,
  input wire logic flash_save_fail,
  input wire logic sensor_meas_req,
  input wire logic stimulus_enable,
  // restore, bias and gating
  input wire logic settings_restore,
  input wire logic offset_clear_wr,
  input wire logic [3:0] offset_clear_index,
  input wire logic [15:0] offset_clear_data,
  input wire logic bias_apply,
  input wire logic sample_ready_line,
  input wire logic halt_data_production,
  input wire logic [15:0] diag_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_stim_up;
    $rose(stimulus_enable);
  endsequence
  sequence s_remeasure;
    ##[0:2] (sensor_meas_req && stimulus_enable);
  endsequence
  sequence s_clear_run;
    offset_clear_index == 4'h0 ##11 (offset_clear_wr && offset_clear_index == 4'hb)
      ##1 !offset_clear_wr;
  endsequence

  property p_stim_order;
    s_stim_up |-> s_remeasure;
  endproperty
  property p_stim_busy;
    stimulus_enable |-> halt_data_production;
  endproperty
  property p_ready_gate;
    halt_data_production [*2] |=> !sample_ready_line;
  endproperty
  property p_clear_run;
    $rose(offset_clear_wr) |-> s_clear_run;
  endproperty
  property p_clear_zero;
    offset_clear_wr |-> offset_clear_data == OFFSET_CLEAR_VALUE && offset_clear_index <= 4'hb;
  endproperty
  property p_restore_pulse;
    settings_restore |-> halt_data_production ##1 !settings_restore;
  endproperty
  property p_bias_pulse;
    bias_apply |-> halt_data_production ##1 !bias_apply;
  endproperty
  property p_crc_flag;
    flash_crc_req && flash_crc_done
      |=> diag_flags[DIAG_FLASH_TEST] == ($past(flash_crc_value) != $past(factory_crc));
  endproperty
  property p_save_flag;
    flash_save_req && flash_save_done |=> diag_flags[DIAG_FLASH_UPDATE] == $past(flash_save_fail);
  endproperty
  property p_idle_clean;
    $fell(halt_data_production)
      |-> !(flash_crc_req || flash_save_req || sensor_meas_req || stimulus_enable);
  endproperty

  a_stim_order: assert property (p_stim_order)
    else $error("stimulus raised without a second measurement");
  a_stim_busy: assert property (p_stim_busy)
    else $error("stimulus active while not halted");
  a_ready_gate: assert property (p_ready_gate)
    else $error("ready pulse while halted");
  a_clear_run: assert property (p_clear_run)
    else $error("offset clear run not twelve writes");
  a_clear_zero: assert property (p_clear_zero)
    else $error("offset clear data or index wrong");
  a_restore_pulse: assert property (p_restore_pulse)
    else $error("restore pulse wrong");
  a_bias_pulse: assert property (p_bias_pulse)
    else $error("bias pulse wrong");
  a_crc_flag: assert property (p_crc_flag)
    else $error("flash test flag wrong");
  a_save_flag: assert property (p_save_flag)
    else $error("flash update flag wrong");
  a_idle_clean: assert property (p_idle_clean)
    else $error("request left over at idle");
endmodule

/* File: dv/igc_global_cmd_bench.sv */
// self-checking bench for the global command block
`timescale 1ns/1ps
module igc_global_cmd_bench;
  import igc_pkg::*;
  localparam logic [15:0] FW = 16'h0104;
  localparam logic [15:0] DM = 16'h1127;
  localparam logic [15:0] YR = 16'h2017;
  // arbitrary identification value
  localparam logic [15:0] PID = 16'h5a5a;
  localparam logic [15:0] SN = 16'h0042;
  localparam logic [15:0] ST_MIN = 16'h0010;
  logic clk, rst_n, sclk, cs_n, din, dout, oe, flash_crc_req, flash_crc_done, flash_save_req;
  logic flash_save_done, flash_save_fail, sensor_meas_req, sensor_meas_done, stimulus_enable;
  logic settings_restore, offset_clear_wr, bias_apply, sample_ready_in, sample_ready_line, halt;
  logic [15:0] flash_crc_value, factory_crc, scr1, offset_clear_data, diag_flags, st_delta;
  logic [15:0] scr2, scr3;
  logic [95:0] sensor_meas_data;
  logic [3:0] offset_clear_index;
  int bad_count, n_compared, cyc, eng_delay, eng_cnt, restore_n, clear_n, bias_n;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  igc_global_cmd #(.FW_REVISION(FW), .CFG_DAY_MONTH(DM), .CFG_YEAR(YR), .PRODUCT_ID(PID),
    .LOT_SERIAL(SN), .ST_DELTA_MIN(ST_MIN), .ST_DELTA_MAX(16'h4000)) dut_u (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(oe), .flash_crc_req(flash_crc_req), .flash_crc_done(flash_crc_done),
    .flash_crc_value(flash_crc_value), .factory_crc(factory_crc),
    .flash_save_req(flash_save_req), .flash_save_done(flash_save_done),
    .flash_save_fail(flash_save_fail), .scratch_one_out(scr1), .scratch_two_out(scr2),
    .scratch_three_out(scr3), .sensor_meas_req(sensor_meas_req),
    .sensor_meas_done(sensor_meas_done), .sensor_meas_data(sensor_meas_data),
    .stimulus_enable(stimulus_enable), .settings_restore(settings_restore),
    .offset_clear_wr(offset_clear_wr), .offset_clear_index(offset_clear_index),
    .offset_clear_data(offset_clear_data), .bias_apply(bias_apply),
    .sample_ready_in(sample_ready_in), .sample_ready_line(sample_ready_line),
    .halt_data_production(halt), .diag_flags(diag_flags));

  igc_spi_host host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // engine stand-in; data reflects the stimulus so order matters
  always @(negedge clk) begin
    flash_crc_done <= 1'b0;
    flash_save_done <= 1'b0;
    sensor_meas_done <= 1'b0;
    sample_ready_in <= rst_n && (cyc % 10 == 0);
    sensor_meas_data <= {6{16'h0100 + (stimulus_enable ? st_delta : 16'h0000)}};
    if (!(flash_crc_req || flash_save_req || sensor_meas_req) || eng_cnt == eng_delay) begin
      eng_cnt <= 0;
    end else begin
      eng_cnt <= eng_cnt + 1;
    end
    if (eng_cnt == eng_delay) begin
      flash_crc_done <= flash_crc_req;
      flash_save_done <= flash_save_req;
      sensor_meas_done <= sensor_meas_req;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    restore_n <= restore_n + int'(settings_restore);
    clear_n <= clear_n + int'(offset_clear_wr && offset_clear_data === 16'h0000);
    bias_n <= bias_n + int'(bias_apply);
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host_u.xfer({1'b1, a, d}, r);
  endtask

  // answer comes in the following frame
  task automatic rdchk(input string what, input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host_u.xfer({1'b0, a, 8'h00}, d);
    host_u.xfer({1'b0, ADDR_PRODUCT_IDENTIFIER, 8'h00}, d);
    chk(what, exp, d);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (halt !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      bad_count++;
      test_done();
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic run(input logic [7:0] bits);
    host_u.command(bits);
    chk("halt", 16'h0001, {15'h0000, halt});
    wait_idle();
  endtask

  initial begin
    rst_n = 1'b0;
    {flash_crc_done, flash_save_done, sensor_meas_done, sample_ready_in} = 4'h0;
    sensor_meas_data = '0;
    {cyc, eng_cnt, restore_n, clear_n, bias_n, bad_count, n_compared} = '0;
    eng_delay = 8;
    flash_save_fail = 1'b0;
    flash_crc_value = 16'hbeef;
    factory_crc = 16'hbeef;
    st_delta = ST_MIN + 16'h0100;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("diag at reset", 16'h0000, diag_flags);
    chk("select idle oe", 16'h0000, {15'h0000, oe});
    wr(ADDR_PRODUCT_IDENTIFIER, 8'h00);
    rdchk("revision", ADDR_FW_REV, FW);
    rdchk("day month", ADDR_CFG_DM, DM);
    rdchk("year", ADDR_CFG_YEAR, YR);
    rdchk("product", ADDR_PRODUCT_IDENTIFIER, PID);
    rdchk("serial", ADDR_SERIAL, SN);
    rdchk("unmapped", 7'h60, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SCR_ONE + 7'(2 * k), 8'(8'h11 * (k + 1)));
      wr(ADDR_SCR_ONE + 7'(2 * k + 1), 8'(8'ha0 + k));
    end
    for (int k = 0; k < 3; k++) begin
      rdchk("scratch", ADDR_SCR_ONE + 7'(2 * k), {8'(8'ha0 + k), 8'(8'h11 * (k + 1))});
    end
    run(8'h08);
    chk("scratch backup", 16'ha011, scr1);
    chk("scratch two backup", 16'ha122, scr2);
    chk("scratch three backup", 16'ha233, scr3);
    chk("update ok", 16'h0000, diag_flags & 16'h0004);
    flash_save_fail = 1'b1;
    run(8'h08);
    chk("update fail", 16'h0004, diag_flags & 16'h0004);
    rdchk("count low", ADDR_FWR_LO, 16'h0002);
    rdchk("count high", ADDR_FWR_HI, 16'h0000);
    run(8'h10);
    chk("crc match", 16'h0000, diag_flags & 16'h0040);
    flash_crc_value = 16'hbeee;
    eng_delay = 80;
    host_u.command(8'h10);
    chk("halt", 16'h0001, {15'h0000, halt});
    wr(ADDR_SCR_ONE, 8'h55);
    wait_idle();
    eng_delay = 8;
    rdchk("ignored write", ADDR_SCR_ONE, 16'ha011);
    chk("crc mismatch", 16'h0040, diag_flags & 16'h0040);
    run(8'h04);
    chk("self test pass", 16'h0000, diag_flags & 16'h0020);
    st_delta = ST_MIN - 16'h0001;
    run(8'h04);
    chk("self test fail", 16'h0020, diag_flags & 16'h0020);
    run(8'h03);
    chk("restore pulses", 16'h0001, 16'(restore_n));
    chk("offset clears", 16'h000c, 16'(clear_n));
    chk("bias pulses", 16'h0001, 16'(bias_n));
    chk("flags held", 16'h0064, diag_flags);
    rdchk("count kept", ADDR_FWR_LO, 16'h0002);
    wr(ADDR_CMD_HI, 8'h00);
    chk("no retrigger", 16'h0000, {15'h0000, halt});
    test_done();
  end
endmodule

bind igc_global_cmd igc_global_cmd_asserts chk_u (
  .clk(clk), .rst_n(rst_n), .flash_crc_req(flash_crc_req), .flash_crc_done(flash_crc_done),
  .flash_crc_value(flash_crc_value), .factory_crc(factory_crc),
  .flash_save_req(flash_save_req), .flash_save_done(flash_save_done),
  .flash_save_fail(flash_save_fail), .sensor_meas_req(sensor_meas_req),
  .stimulus_enable(stimulus_enable), .settings_restore(settings_restore),
  .offset_clear_wr(offset_clear_wr), .offset_clear_index(offset_clear_index),
  .offset_clear_data(offset_clear_data), .bias_apply(bias_apply),
  .sample_ready_line(sample_ready_line), .halt_data_production(halt_data_production),
  .diag_flags(diag_flags));

/* File: dv/igc_spi_host.sv */
// serial host model: frames words and issues commands
`timescale 1ns/1ps
module igc_spi_host
  import igc_pkg::*;
(
  // pacing clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    @(negedge clk);
    cs_n = 1'b0;
    #3;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = w[i];
      #3;
      sclk = 1'b1;
      r[i] = dout;
      #3;
    end
    cs_n = 1'b1;
    // released line must not look like a held bit
    din = ~w[0];
    // stall above 500 ns between frames
    repeat (6) @(negedge clk);
  endtask

  task automatic command(input logic [7:0] bits);
    logic [15:0] r;
    xfer({1'b1, ADDR_CMD_LO, bits}, r);
    xfer({1'b1, ADDR_CMD_HI, 8'h00}, r);
  endtask
endmodule

/* File: shared/igc_pkg.sv */
// constants for the global command and information register block
package igc_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 7;
  localparam int SENSOR_N = 6;
  localparam int OFFSET_REG_N = 12;

  // byte addresses on the serial port
  localparam logic [6:0] ADDR_CMD_LO = 7'h68;
  localparam logic [6:0] ADDR_CMD_HI = 7'h69;
  localparam logic [6:0] ADDR_FW_REV = 7'h6c;
  localparam logic [6:0] ADDR_CFG_DM = 7'h6e;
  localparam logic [6:0] ADDR_CFG_YEAR = 7'h70;
  localparam logic [6:0] ADDR_PRODUCT_IDENTIFIER = 7'h72;
  localparam logic [6:0] ADDR_SERIAL = 7'h74;
  localparam logic [6:0] ADDR_SCR_ONE = 7'h76;
  localparam logic [6:0] ADDR_SCR_TWO = 7'h78;
  localparam logic [6:0] ADDR_SCR_THREE = 7'h7a;
  localparam logic [6:0] ADDR_FWR_LO = 7'h7c;
  localparam logic [6:0] ADDR_FWR_HI = 7'h7e;

  // command trigger bit positions
  localparam int CMD_FLASH_TEST = 4;
  localparam int CMD_FLASH_UPDATE = 3;
  localparam int CMD_SELF_TEST = 2;
  localparam int CMD_RESTORE = 1;
  localparam int CMD_BIAS_UPDATE = 0;
  localparam int CMD_N = 5;

  // diagnostic flag bit positions
  localparam int DIAG_FLASH_TEST = 6;
  localparam int DIAG_SELF_TEST = 5;
  localparam int DIAG_FLASH_UPDATE = 2;

  // reset values
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [31:0] FWR_COUNT_RST = 32'h0000_0000;
  localparam logic [15:0] OFFSET_CLEAR_VALUE = 16'h0000;

  typedef enum logic [9:0] {
    IGC_IDLE     = 10'b00_0000_0001,
    IGC_FTEST    = 10'b00_0000_0010,
    IGC_FSAVE    = 10'b00_0000_0100,
    IGC_SMEAS0   = 10'b00_0000_1000,
    IGC_SSTIM    = 10'b00_0001_0000,
    IGC_SMEAS1   = 10'b00_0010_0000,
    IGC_SUNSTIM  = 10'b00_0100_0000,
    IGC_SJUDGE   = 10'b00_1000_0000,
    IGC_RESTORE  = 10'b01_0000_0000,
    IGC_BIAS     = 10'b10_0000_0000
  } igc_state_t;
endpackage
